// File: hdl/adcsc_pkg.sv
// Package of offsets, field layouts, reset values and carrier types for the scan control block.
package adcsc_pkg;

   // ==========================================================================
   // Register offsets on the serial register port.
   localparam logic [6:0] ADCSC_OFS_RESET_CTRL = 7'h00;
   localparam logic [6:0] ADCSC_OFS_RESTART = 7'h0B;
   localparam logic [6:0] ADCSC_OFS_AUX = 7'h12;
   localparam logic [6:0] ADCSC_OFS_READY = 7'h18;
   localparam logic [6:0] ADCSC_OFS_RES_HI = 7'h1A;
   localparam logic [6:0] ADCSC_OFS_RES_LO = 7'h1B;
   localparam logic [6:0] ADCSC_OFS_CH_STATUS = 7'h1E;
   localparam logic [6:0] ADCSC_OFS_SCAN = 7'h1F;

   // ==========================================================================
   // Command values and field positions.
   localparam logic [7:0] ADCSC_FULL_RESET_CODE = 8'hC3;
   localparam int ADCSC_RESTART_BIT = 0;
   localparam int ADCSC_AUX_CALCLR_BIT = 6;
   localparam int ADCSC_AUX_BYPASS_BIT = 5;
   localparam int ADCSC_AUX_CLKSEL_BIT = 4;
   localparam int ADCSC_STS_PENDING_BIT = 1;
   localparam int ADCSC_STS_STALE_BIT = 0;
   localparam logic [2:0] ADCSC_CH_ILLEGAL = 3'h7;

   // ==========================================================================
   // Reset values and fixed read answers.
   localparam logic [7:0] ADCSC_AUX_RESET = 8'h00;
   localparam logic [7:0] ADCSC_SCAN_RESET = 8'h30;
   localparam logic [7:0] ADCSC_READY_NONE = 8'hFF;
   localparam logic [7:0] ADCSC_READY_FRESH = 8'h00;
   localparam logic [7:0] ADCSC_READ_ZERO = 8'h00;
   localparam logic [15:0] ADCSC_RESULT_RESET = 16'h0000;
   localparam logic [3:0] ADCSC_CUR_MAX = 4'hA;

   // ==========================================================================
   // Timing: least spacing of repeated result reads, kept by the host.
   localparam int ADCSC_CLK_HZ = 25_000_000;
   localparam int ADCSC_REPEAT_READ_GAP_US = 72;
   localparam int ADCSC_REPEAT_READ_GAP_CYC =
      (ADCSC_REPEAT_READ_GAP_US * (ADCSC_CLK_HZ / 1_000_000));

   // ==========================================================================
   // Types.
   typedef enum logic [1:0]
   {
      ADCSC_SCAN_SINGLE_CONT = 2'b00,
      ADCSC_SCAN_ONCE = 2'b01,
      ADCSC_SCAN_CONT = 2'b10,
      ADCSC_SCAN_CONT_BURNOUT = 2'b11
   } adcsc_scan_mode_t;

   typedef struct packed
   {
      logic calib_clear_on_full_reset;
      logic ext_clock_detect_bypass;
      logic clock_sel_ext;
      logic [3:0] excitation_current_select;
   } adcsc_aux_t;

   typedef struct packed
   {
      adcsc_scan_mode_t scan_mode_select;
      logic [2:0] final_channel;
      logic [2:0] starting_channel;
   } adcsc_scan_t;

   typedef struct packed
   {
      logic [6:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } adcsc_req_t;

endpackage : adcsc_pkg

// File: hdl/adcsc_result.sv
// Result holding register with fresh and stale tracking for the scan control block.
module adcsc_result
(
   mclk,
   reset_n,
   soft_reset,
   conv_valid,
   conv_data,
   rd_high,
   rd_low,
   result,
   fresh,
   stale_read_flag
);
   import adcsc_pkg::*;

   input wire logic mclk;
   input wire logic reset_n;
   input wire logic soft_reset;
   input wire logic conv_valid;
   input wire logic [15:0] conv_data;
   input wire logic rd_high;
   input wire logic rd_low;
   output logic [15:0] result;
   output logic fresh;
   output logic stale_read_flag;

   logic [15:0] result_r;
   logic fresh_r;
   logic stale_r;
   logic read_any;
   logic fresh_nxt;

   // ==========================================================================
   // A new result marks fresh; the low byte read consumes it, but a result landing
   // in the same cycle wins so no conversion is silently lost.
   assign read_any = rd_high | rd_low;
   assign fresh_nxt = conv_valid | (fresh_r & ~rd_low);

   // Latch the result and flags.
   always_ff @(posedge mclk)
   begin
      if (!reset_n || soft_reset)
      begin
         result_r <= ADCSC_RESULT_RESET;
         fresh_r <= 1'b0;
         stale_r <= 1'b0;
      end
      else
      begin
         if (conv_valid)
         begin
            result_r <= conv_data;
         end
         fresh_r <= fresh_nxt;
         if (read_any)
         begin
            stale_r <= ~fresh_r;
         end
      end
   end

   assign result = result_r;
   assign fresh = fresh_r;
   assign stale_read_flag = stale_r;

endmodule : adcsc_result

// File: hdl/adcsc_top.sv
// Control and status registers for the converter restart, auxiliary and scan options.
// Summary of operation
// - Writing one to restart bit 0 aborts and restarts conversion; other bits reserved.
// - Full reset clears system offset and gain coefficients only when option bit set.
// - Auxiliary bit 5 zero runs external clock detection; one bypasses it.
// - Clock select bit counts only when detection bypassed; one picks external clock.
// - Four-bit excitation current in 100 microamp steps, up to code 0xA, reset zero.
// - Data-available reads 0xFF with no new result, other values when fresh.
// - Result is 16-bit two's complement, high byte then low byte, next reserved.
// - Status bit 1 reads one while a scan update is pending.
// - Status bit 0 is zero for valid unread result, one for stale or repeat.
// - Two-bit scan mode: single continuous, one scan, continuous, continuous with burnout.
// - Three-bit last channel field, codes 0 to 6, reset value 6.
// - Scan write holding code 7 in either channel field is discarded whole.
// - Three-bit first channel field, codes 0 to 6, reset value 0.
// - Writing 0xC3 to reset control resets registers and restarts; other values ignored.
module adcsc_top
(
   mclk,
   reset_n,
   reg_req,
   reg_rdata,
   conv_valid,
   conv_data,
   scan_update_ack,
   ext_clock_present,
   conv_restart,
   full_reset_pulse,
   calib_clear_pulse,
   aux_cfg,
   scan_cfg,
   use_ext_clock,
   ext_detect_enable
);
   import adcsc_pkg::*;

   input wire logic mclk;
   input wire logic reset_n;
   input wire adcsc_pkg::adcsc_req_t reg_req;
   output logic [7:0] reg_rdata;
   input wire logic conv_valid;
   input wire logic [15:0] conv_data;
   input wire logic scan_update_ack;
   input wire logic ext_clock_present;
   output logic conv_restart;
   output logic full_reset_pulse;
   output logic calib_clear_pulse;
   output adcsc_pkg::adcsc_aux_t aux_cfg;
   output adcsc_pkg::adcsc_scan_t scan_cfg;
   output logic use_ext_clock;
   output logic ext_detect_enable;

   // ==========================================================================
   // Declarations.
   adcsc_aux_t aux_r;
   adcsc_aux_t aux_nxt;
   adcsc_scan_t scan_r;
   adcsc_scan_t scan_nxt;
   logic pending_r;
   logic pending_nxt;
   logic restart_r;
   logic full_reset_r;
   logic calib_clear_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic ext_meta_r;
   logic ext_sync_r;
   logic wr_reset_ctrl;
   logic wr_restart;
   logic wr_aux;
   logic wr_scan;
   logic full_reset_hit;
   logic scan_write_legal;
   logic rd_high;
   logic rd_low;
   logic [15:0] result;
   logic fresh;
   logic stale_read_flag;
   logic [3:0] cur_in;

   // ==========================================================================
   // Write and result read decode on the register port.
   assign wr_reset_ctrl = reg_req.wr && (reg_req.addr == ADCSC_OFS_RESET_CTRL);
   assign wr_restart = reg_req.wr && (reg_req.addr == ADCSC_OFS_RESTART);
   assign wr_aux = reg_req.wr && (reg_req.addr == ADCSC_OFS_AUX);
   assign wr_scan = reg_req.wr && (reg_req.addr == ADCSC_OFS_SCAN);
   assign rd_high = reg_req.rd && (reg_req.addr == ADCSC_OFS_RES_HI);
   assign rd_low = reg_req.rd && (reg_req.addr == ADCSC_OFS_RES_LO);

   // Only the exact full reset code acts; every other value is dropped.
   assign full_reset_hit = wr_reset_ctrl && (reg_req.wdata == ADCSC_FULL_RESET_CODE);

   // A channel code of 7 in either field voids the whole scan write.
   assign scan_write_legal = (reg_req.wdata[5:3] != ADCSC_CH_ILLEGAL) &&
                             (reg_req.wdata[2:0] != ADCSC_CH_ILLEGAL);

   // ==========================================================================
   // Auxiliary control next value. Current codes above the top step are clipped so
   // the current source is never asked for a step it does not have.
   assign cur_in = (reg_req.wdata[3:0] > ADCSC_CUR_MAX) ? ADCSC_CUR_MAX : reg_req.wdata[3:0];
   always_comb
   begin
      aux_nxt = aux_r;
      if (wr_aux)
      begin
         aux_nxt.calib_clear_on_full_reset = reg_req.wdata[ADCSC_AUX_CALCLR_BIT];
         aux_nxt.ext_clock_detect_bypass = reg_req.wdata[ADCSC_AUX_BYPASS_BIT];
         aux_nxt.clock_sel_ext = reg_req.wdata[ADCSC_AUX_CLKSEL_BIT];
         aux_nxt.excitation_current_select = cur_in;
      end
   end

   // Scan control next value; the write also raises the update pending flag.
   always_comb
   begin
      scan_nxt = scan_r;
      if (wr_scan && scan_write_legal)
      begin
         scan_nxt.scan_mode_select = adcsc_scan_mode_t'(reg_req.wdata[7:6]);
         scan_nxt.final_channel = reg_req.wdata[5:3];
         scan_nxt.starting_channel = reg_req.wdata[2:0];
      end
   end

   // The core acknowledges the update; a new write in the same cycle keeps it pending.
   assign pending_nxt = (wr_scan && scan_write_legal) | (pending_r & ~scan_update_ack);

   // ==========================================================================
   // Control registers. A full reset returns them to their reset values.
   always_ff @(posedge mclk)
   begin
      if (!reset_n || full_reset_hit)
      begin
         aux_r <= adcsc_aux_t'(ADCSC_AUX_RESET[6:0]);
         scan_r <= adcsc_scan_t'(ADCSC_SCAN_RESET);
         pending_r <= 1'b0;
      end
      else
      begin
         aux_r <= aux_nxt;
         scan_r <= scan_nxt;
         pending_r <= pending_nxt;
      end
   end

   // ==========================================================================
   // Command pulses. Restart holds for one cycle and then drops by itself, so
   // software never has to write a zero back.
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         restart_r <= 1'b0;
         full_reset_r <= 1'b0;
         calib_clear_r <= 1'b0;
      end
      else
      begin
         restart_r <= (wr_restart && reg_req.wdata[ADCSC_RESTART_BIT]) || full_reset_hit;
         full_reset_r <= full_reset_hit;
         calib_clear_r <= full_reset_hit && aux_r.calib_clear_on_full_reset;
      end
   end

   // ==========================================================================
   // External clock presence arrives from a pin and is synchronised first.
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
      end
      else
      begin
         ext_meta_r <= ext_clock_present;
         ext_sync_r <= ext_meta_r;
      end
   end

   // With detection running the detector decides; when bypassed the select bit does.
   assign ext_detect_enable = ~aux_r.ext_clock_detect_bypass;
   assign use_ext_clock = aux_r.ext_clock_detect_bypass ? aux_r.clock_sel_ext : ext_sync_r;

   // ==========================================================================
   // Result holding and read tracking.
   adcsc_result u_result
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .soft_reset(full_reset_hit),
      .conv_valid(conv_valid),
      .conv_data(conv_data),
      .rd_high(rd_high),
      .rd_low(rd_low),
      .result(result),
      .fresh(fresh),
      .stale_read_flag(stale_read_flag)
   );

   // ==========================================================================
   // Read multiplexer; write-only, reserved and unmapped addresses read zero.
   always_comb
   begin
      rdata_nxt = ADCSC_READ_ZERO;
      unique case (reg_req.addr)
         ADCSC_OFS_AUX:
         begin
            rdata_nxt = {1'b0, aux_r};
         end
         ADCSC_OFS_READY:
         begin
            rdata_nxt = fresh ? ADCSC_READY_FRESH : ADCSC_READY_NONE;
         end
         ADCSC_OFS_RES_HI:
         begin
            rdata_nxt = result[15:8];
         end
         ADCSC_OFS_RES_LO:
         begin
            rdata_nxt = result[7:0];
         end
         ADCSC_OFS_CH_STATUS:
         begin
            rdata_nxt = {6'b00_0000, pending_r, stale_read_flag};
         end
         ADCSC_OFS_SCAN:
         begin
            rdata_nxt = scan_r;
         end
         default:
         begin
            rdata_nxt = ADCSC_READ_ZERO;
         end
      endcase
   end

   // Read data is registered so the serial shifter sees a stable byte.
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         rdata_r <= ADCSC_READ_ZERO;
      end
      else if (reg_req.rd)
      begin
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================================
   // Outputs.
   assign reg_rdata = rdata_r;
   assign conv_restart = restart_r;
   assign full_reset_pulse = full_reset_r;
   assign calib_clear_pulse = calib_clear_r;
   assign aux_cfg = aux_r;
   assign scan_cfg = scan_r;

endmodule : adcsc_top

// File: tb/adcsc_asserts.sv
// Concurrent checker for the scan control block, watching its top-level ports only.
module adcsc_asserts
(
   mclk,
   reset_n,
   reg_req,
   reg_rdata,
   conv_valid,
   scan_update_ack,
   conv_restart,
   full_reset_pulse,
   calib_clear_pulse,
   aux_cfg,
   scan_cfg,
   use_ext_clock,
   ext_detect_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   import adcsc_pkg::*;
   input wire logic mclk;
   input wire logic reset_n;
   input wire adcsc_pkg::adcsc_req_t reg_req;
   input wire logic [7:0] reg_rdata;
   input wire logic conv_valid;
   input wire logic scan_update_ack;
   input wire logic conv_restart;
   input wire logic full_reset_pulse;
   input wire logic calib_clear_pulse;
   input wire adcsc_pkg::adcsc_aux_t aux_cfg;
   input wire adcsc_pkg::adcsc_scan_t scan_cfg;
   input wire logic use_ext_clock;
   input wire logic ext_detect_enable;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // ==========================================================================
   // Request decodes; a scan write holding code 7 in a channel field is illegal.
   wire wr_rst = reg_req.wr && reg_req.addr == ADCSC_OFS_RESET_CTRL;
   wire wr_rs = reg_req.wr && reg_req.addr == ADCSC_OFS_RESTART;
   wire wr_sc = reg_req.wr && reg_req.addr == ADCSC_OFS_SCAN;
   wire sc_bad = reg_req.wdata[5:3] == ADCSC_CH_ILLEGAL || reg_req.wdata[2:0] == ADCSC_CH_ILLEGAL;

   // ==========================================================================
   // Multi-step behaviours: a fresh result, and a scan update still pending.
   sequence s_fresh;
      conv_valid ##1 !(reg_req.rd || reg_req.wr)
         ##1 (reg_req.rd && reg_req.addr == ADCSC_OFS_READY);
   endsequence
   sequence s_pend;
      (wr_sc && !sc_bad) ##1 !scan_update_ack
         ##1 (reg_req.rd && reg_req.addr == ADCSC_OFS_CH_STATUS && !scan_update_ack);
   endsequence

   chk_restart_pulse: assert property (wr_rs && reg_req.wdata[0] |=>
      conv_restart ##1 !conv_restart)
      else $error("restart pulse wrong");
   chk_restart_quiet: assert property (wr_rs && !reg_req.wdata[0] |=> !conv_restart)
      else $error("restart without command");
   chk_full_reset: assert property (wr_rst && reg_req.wdata == ADCSC_FULL_RESET_CODE |=>
      full_reset_pulse && 7'(aux_cfg) == 7'h00 && 8'(scan_cfg) == ADCSC_SCAN_RESET)
      else $error("full reset not applied");
   chk_reset_ignore: assert property (wr_rst && reg_req.wdata != ADCSC_FULL_RESET_CODE |=>
      !full_reset_pulse && $stable(aux_cfg))
      else $error("reset code not ignored");
   chk_calib_clear: assert property (full_reset_pulse |->
      calib_clear_pulse == $past(aux_cfg.calib_clear_on_full_reset))
      else $error("calibration clear wrong");
   chk_detect_level: assert property (ext_detect_enable != aux_cfg.ext_clock_detect_bypass)
      else $error("detect enable wrong");
   chk_clock_select: assert property (aux_cfg.ext_clock_detect_bypass |->
      use_ext_clock == aux_cfg.clock_sel_ext)
      else $error("clock select wrong");
   chk_current_limit: assert property (aux_cfg.excitation_current_select <= ADCSC_CUR_MAX)
      else $error("current code out of range");
   chk_scan_reject: assert property (wr_sc && sc_bad |=> $stable(scan_cfg))
      else $error("illegal scan write taken");
   chk_scan_accept: assert property (wr_sc && !sc_bad |=>
      8'(scan_cfg) == $past(reg_req.wdata))
      else $error("scan write lost");
   chk_ready_fresh: assert property (s_fresh |=> reg_rdata == ADCSC_READY_FRESH)
      else $error("ready not shown");
   chk_pending_flag: assert property (s_pend |=> reg_rdata[ADCSC_STS_PENDING_BIT])
      else $error("pending flag missing");
endmodule : adcsc_asserts

// File: tb/adcsc_host.sv
// Behavioural serial host that issues register requests to the scan control block.
module adcsc_host
(
   mclk,
   reg_req,
   reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import adcsc_pkg::*;
   input wire logic mclk;
   output adcsc_pkg::adcsc_req_t reg_req;
   input wire logic [7:0] reg_rdata;
   int cyc = 0;
   int last_res = -100000;

   // Free cycle count used to space repeated result reads.
   always @(posedge mclk) cyc++;
   initial reg_req = '0;

   // Idle fields show the inverse of the last request so nothing stale looks valid.
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1 reg_req = '{a, 1'b1, 1'b0, d};
      @(posedge mclk);
      #1 reg_req = '{~a, 1'b0, 1'b0, ~d};
   endtask : wr

   task rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1 reg_req = '{a, 1'b0, 1'b1, 8'h00};
      @(posedge mclk);
      #1 d = reg_rdata;
      reg_req = '{~a, 1'b0, 1'b0, 8'hFF};
   endtask : rd

   // Scan control is only written once no update is pending.
   task wr_scan(input logic [7:0] d);
      logic [7:0] s;
      s = 8'hFF;
      while (s[ADCSC_STS_PENDING_BIT]) rd(ADCSC_OFS_CH_STATUS, s);
      wr(ADCSC_OFS_SCAN, d);
   endtask : wr_scan

   // Result pairs are spaced by the repeat gap, trading run time for legal traffic.
   task rd_res(output logic [7:0] hi, output logic [7:0] lo);
      while (cyc - last_res < ADCSC_REPEAT_READ_GAP_CYC) @(posedge mclk);
      rd(ADCSC_OFS_RES_HI, hi);
      rd(ADCSC_OFS_RES_LO, lo);
      last_res = cyc;
   endtask : rd_res
endmodule : adcsc_host

// File: tb/testbench.sv
// Self-checking bench for the scan control block with host model and checker.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import adcsc_pkg::*;
   logic mclk, reset_n, conv_valid, scan_update_ack, ext_clock_present;
   logic conv_restart, full_reset_pulse, calib_clear_pulse, use_ext_clock, ext_detect_enable;
   logic [15:0] conv_data;
   logic [7:0] reg_rdata, d, lf, hi, lo;
   logic [3:0] ack_sr;
   adcsc_req_t reg_req;
   adcsc_aux_t aux_cfg;
   adcsc_scan_t scan_cfg;
   int errors, n_checks, m_aux, m_scan, m, i;
   int q[$];

   adcsc_top u_dut (.mclk, .reset_n, .reg_req, .reg_rdata, .conv_valid, .conv_data,
      .scan_update_ack, .ext_clock_present, .conv_restart, .full_reset_pulse,
      .calib_clear_pulse, .aux_cfg, .scan_cfg, .use_ext_clock, .ext_detect_enable);
   adcsc_host u_host (.mclk, .reg_req, .reg_rdata);

   initial
   begin
      mclk = 0;
      forever #20 mclk = ~mclk;
   end

   // Core stand-in: acknowledges every scan write a few cycles later.
   always @(posedge mclk)
   begin
      ack_sr <= {ack_sr[2:0], reg_req.wr && reg_req.addr == ADCSC_OFS_SCAN};
      scan_update_ack <= ack_sr[3];
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task rdchk(input logic [6:0] a, input int e, input string nm);
      u_host.rd(a, d);
      check(nm, 16'(d), 16'(e));
   endtask : rdchk

   task tally_and_finish;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // ==========================================================================
   // Watchdog sized well beyond the spaced result reads.
   initial
   begin
      #2_000_000;
      errors++;
      tally_and_finish;
   end

   // ==========================================================================
   // Main sequence.
   initial
   begin
      reset_n = 0;
      conv_valid = 0;
      conv_data = 16'h0000;
      ext_clock_present = 0;
      scan_update_ack = 0;
      ack_sr = 4'h0;
      lf = 8'h2C;
      m_scan = 'h30;
      repeat (2) @(posedge mclk);
      #1 reset_n = 1;
      rdchk(ADCSC_OFS_AUX, 0, "aux_reset");
      rdchk(ADCSC_OFS_SCAN, 'h30, "scan_reset");
      rdchk(ADCSC_OFS_READY, 'hFF, "ready_reset");
      rdchk(ADCSC_OFS_CH_STATUS, 0, "status_reset");
      rdchk(7'h1C, 0, "reserved_read");
      for (i = 0; i < 14; i++)
      begin
         lf = lfsr(lf);
         u_host.wr(ADCSC_OFS_AUX, lf);
         m_aux = (lf[3:0] > 4'hA) ? {lf[6:4], 4'hA} : lf[6:0];
         rdchk(ADCSC_OFS_AUX, m_aux, "aux_rw");
         check("detect_en", 16'(ext_detect_enable), 16'(!lf[5]));
         if (lf[5])
            check("clk_sel", 16'(use_ext_clock), 16'(lf[4]));
         else
            check("clk_det", 16'(use_ext_clock), 16'h0000);
         lf = lfsr(lf);
         d = lf;
         if (d[5:3] != 7 && d[2:0] != 7 && d[5:3] < d[2:0]) d = {d[7:6], d[2:0], d[5:3]};
         if (i == 0) d[5:3] = 3'h7;
         u_host.wr_scan(d);
         u_host.rd(ADCSC_OFS_CH_STATUS, hi);
         check("pending", 16'(hi[1]), 16'(d[5:3] != 7 && d[2:0] != 7));
         if (d[5:3] != 7 && d[2:0] != 7) m_scan = d;
         rdchk(ADCSC_OFS_SCAN, m_scan, "scan_rw");
      end
      u_host.wr(ADCSC_OFS_AUX, 8'h00);
      ext_clock_present = 1;
      repeat (4) @(posedge mclk);
      #1 check("ext_detect", 16'(use_ext_clock), 16'h0001);
      for (i = 0; i < 3; i++)
      begin
         lf = lfsr(lf);
         @(posedge mclk);
         #1 conv_valid = 1;
         conv_data = {lf, lfsr(lf)};
         q.push_back(conv_data);
         @(posedge mclk);
         #1 conv_valid = 0;
         rdchk(ADCSC_OFS_READY, 0, "ready_fresh");
         m = q.pop_front();
         u_host.rd_res(hi, lo);
         check("result", {hi, lo}, 16'(m));
         rdchk(ADCSC_OFS_CH_STATUS, 0, "stale_clear");
         u_host.rd_res(hi, lo);
         check("result_rpt", {hi, lo}, 16'(m));
         rdchk(ADCSC_OFS_CH_STATUS, 1, "stale_set");
         rdchk(ADCSC_OFS_READY, 'hFF, "ready_none");
      end
      u_host.wr(ADCSC_OFS_RESTART, 8'h01);
      check("restart", 16'(conv_restart), 16'h0001);
      @(posedge mclk);
      #1 check("restart_end", 16'(conv_restart), 16'h0000);
      u_host.wr(ADCSC_OFS_RESTART, 8'hFE);
      check("restart_rsv", 16'(conv_restart), 16'h0000);
      rdchk(ADCSC_OFS_RESTART, 0, "restart_rd");
      u_host.wr(ADCSC_OFS_AUX, 8'h45);
      u_host.wr(ADCSC_OFS_RESET_CTRL, 8'h3C);
      rdchk(ADCSC_OFS_AUX, 'h45, "reset_ignored");
      u_host.wr(ADCSC_OFS_RESET_CTRL, 8'hC3);
      check("calib_clear", 16'(calib_clear_pulse), 16'h0001);
      check("full_reset", 16'(full_reset_pulse), 16'h0001);
      check("restart_full", 16'(conv_restart), 16'h0001);
      rdchk(ADCSC_OFS_AUX, 0, "aux_after_reset");
      rdchk(ADCSC_OFS_CH_STATUS, 0, "status_after_reset");
      rdchk(ADCSC_OFS_SCAN, 'h30, "scan_after_reset");
      u_host.wr(ADCSC_OFS_RESET_CTRL, 8'hC3);
      check("calib_keep", 16'(calib_clear_pulse), 16'h0000);
      tally_and_finish;
   end
endmodule : testbench

bind adcsc_top adcsc_asserts u_chk (.mclk, .reset_n, .reg_req, .reg_rdata, .conv_valid,
   .scan_update_ack, .conv_restart, .full_reset_pulse, .calib_clear_pulse, .aux_cfg,
   .scan_cfg, .use_ext_clock, .ext_detect_enable);
